// [core/cxv_top.sv]
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "cxv_consts.svh"
// Notes on behaviour
// (RULE1) Exceptions abort; interrupts let instruction finish.
// (RULE2) Interrupt acted on only at instruction end.
// (RULE3) Save PC and SR before changing them.
// (RULE4) Entry sets block_mask to one.
// (RULE5) Entry sets priv_mode to one.
// (RULE6) Entry sets bank_select to one.
// (RULE7) Event code written to code registers.
// (RULE8) Then branch to the event vector.
// (RULE9) All resets fetch fixed reset vector, abort.
// (RULE10) TLB miss vectors to base plus 400; a data miss inside a repeat loop takes base plus 100 here.
// (RULE11) Other general exceptions: base plus 100.
// (RULE12) Interrupts vector to base plus 600.
// (RULE13) Software loads the vector base.
// (RULE14) Vector base should lie in fixed regions.
// (RULE15) Return restores PC and SR from saves.
// (RULE16) Resets first; fetch-side errors ordered one to four.
// (RULE17) Illegal, slot, trap share order five.
// (RULE18) Data-side order six to ten, DMA twelve.
// (RULE19) Abort types retry; trap, breakpoint, DMA complete.
// (RULE20) Exception under block_mask resets; interrupts held.
// (RULE21) Power-on reset beats manual reset.
module cxv_top (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic por_i,
  input wire logic man_reset_i,
  input wire logic debug_port_reset_i,
  input wire cxv_pkg::cxv_exc_req_t exc_i,
  input wire logic irq_i,
  input wire logic [11:0] irq_code_i,
  input wire logic instr_end_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] next_pc_i,
  input wire logic exc_ret_i,
  output logic [31:0] target_pc_o,
  output logic branch_o,
  output logic abort_o,
  output logic cpu_regs_reset_o,
  output logic [31:0] sr_o
);
  import cxv_pkg::*;

  cxv_state_t s_r;
  cxv_state_t s_nxt;
  logic any_reset;
  logic abort_any;
  logic comp_any;
  logic [11:0] ab_code;
  logic [31:0] ab_ofs;
  logic [11:0] cp_code;
  logic blk;

  assign blk = s_r.sr[`CXV_SR_BLOCK_BIT];
  assign any_reset = por_i | man_reset_i | debug_port_reset_i;
  assign abort_any = exc_i.i_adr | exc_i.i_miss | exc_i.i_inv | exc_i.i_prot | exc_i.illegal
                   | exc_i.slot | exc_i.d_adr | exc_i.d_miss | exc_i.d_inv | exc_i.d_prot
                   | exc_i.ipw; // [RULE19]
  assign comp_any = exc_i.trap | exc_i.bkpt | exc_i.dma; // [RULE19]

  // Abort-type events, earliest order within the instruction first.
  always_comb begin
    ab_code = `CXV_EC_IPW;
    ab_ofs = `CXV_OFS_GEN; // [RULE11]
    if (exc_i.i_adr) begin
      ab_code = `CXV_EC_ADR_LD; // [RULE16]
    end else if (exc_i.i_miss) begin
      ab_code = `CXV_EC_TLB_LD;
      ab_ofs = `CXV_OFS_TLB; // [RULE10]
    end else if (exc_i.i_inv) begin
      ab_code = `CXV_EC_TLB_LD;
    end else if (exc_i.i_prot) begin
      ab_code = `CXV_EC_PROT_LD;
    end else if (exc_i.illegal) begin
      ab_code = `CXV_EC_ILL; // [RULE17]
    end else if (exc_i.slot) begin
      ab_code = `CXV_EC_SLOT;
    end else if (exc_i.d_adr) begin
      ab_code = exc_i.d_store ? `CXV_EC_ADR_ST : `CXV_EC_ADR_LD; // [RULE18]
    end else if (exc_i.d_miss) begin
      ab_code = exc_i.d_store ? `CXV_EC_TLB_ST : `CXV_EC_TLB_LD;
      // A miss inside a repeat loop takes the general offset.
      ab_ofs = exc_i.d_in_repeat ? `CXV_OFS_GEN : `CXV_OFS_TLB; // [RULE10]
    end else if (exc_i.d_inv) begin
      ab_code = exc_i.d_store ? `CXV_EC_TLB_ST : `CXV_EC_TLB_LD;
    end else if (exc_i.d_prot) begin
      ab_code = exc_i.d_store ? `CXV_EC_PROT_ST : `CXV_EC_PROT_LD;
    end
  end

  // Completion-type events; trap shares order five but only meets the others here.
  always_comb begin
    cp_code = `CXV_EC_DMA; // [RULE18]
    if (exc_i.trap) begin
      cp_code = `CXV_EC_TRAP; // [RULE17]
    end else if (exc_i.bkpt) begin
      cp_code = `CXV_EC_BKPT;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.branch = 1'b0;
    s_nxt.abort = 1'b0;
    s_nxt.creset = 1'b0;
    if (s_r.rd_pend) begin
      s_nxt.rd_pend = 1'b0;
      s_nxt.hready = 1'b1;
      s_nxt.hrdata = 32'h00000000;
      if (s_r.hit) begin
        unique case (s_r.idx)
          `CXV_IDX_VBASE: s_nxt.hrdata = s_r.vbase;
          `CXV_IDX_SVPC: s_nxt.hrdata = s_r.svpc;
          `CXV_IDX_SVSR: s_nxt.hrdata = s_r.svsr;
          `CXV_IDX_SR: s_nxt.hrdata = s_r.sr;
          `CXV_IDX_EVCODE: s_nxt.hrdata = {20'h00000, s_r.evcode};
          `CXV_IDX_ICODE: s_nxt.hrdata = {20'h00000, s_r.icode};
          `CXV_IDX_ICODE2: s_nxt.hrdata = {20'h00000, s_r.icode2};
          `CXV_IDX_PC: s_nxt.hrdata = s_r.pc;
        endcase
      end
    end
    if (s_r.wr_pend) begin
      s_nxt.wr_pend = 1'b0;
      if (s_r.hit) begin
        unique case (s_r.idx)
          `CXV_IDX_VBASE: s_nxt.vbase = hwdata_i; // [RULE13]
          `CXV_IDX_SVPC: s_nxt.svpc = hwdata_i;
          `CXV_IDX_SVSR: s_nxt.svsr = hwdata_i;
          `CXV_IDX_SR: s_nxt.sr = hwdata_i;
          `CXV_IDX_EVCODE: s_nxt.evcode = hwdata_i[11:0];
          default: s_nxt.idx = s_r.idx;
        endcase
      end
    end
    // Reads wait one cycle so a write just before them is already visible.
    if (hsel_i && htrans_i[1] && hready_i) begin
      s_nxt.idx = haddr_i[4:2];
      s_nxt.hit = (haddr_i[31:5] == 27'h0000000);
      s_nxt.wr_pend = hwrite_i;
      s_nxt.rd_pend = !hwrite_i;
      s_nxt.hready = hwrite_i;
    end
    // Hardware events come last so they win over a software write.
    if (any_reset) begin
      s_nxt.evcode = por_i ? `CXV_EC_POR : (man_reset_i ? `CXV_EC_MAN : `CXV_EC_DBG); // [RULE21]
      s_nxt.pc = `CXV_RESET_VEC; // [RULE9]
      s_nxt.sr = `CXV_SR_RST;
      s_nxt.branch = 1'b1;
      s_nxt.abort = 1'b1;
      s_nxt.creset = 1'b1;
    end else if (abort_any || (instr_end_i && comp_any)) begin
      s_nxt.branch = 1'b1; // [RULE8]
      s_nxt.abort = abort_any; // [RULE1]
      if (blk) begin
        // Nested exception under block_mask cannot be saved safely.
        s_nxt.pc = `CXV_RESET_VEC; // [RULE20]
        s_nxt.sr = `CXV_SR_RST;
        s_nxt.creset = 1'b1;
      end else begin
        s_nxt.svpc = abort_any ? pc_i : next_pc_i; // [RULE3] [RULE19]
        s_nxt.svsr = s_r.sr; // [RULE3]
        s_nxt.sr[`CXV_SR_BLOCK_BIT] = 1'b1; // [RULE4]
        s_nxt.sr[`CXV_SR_PRIV_BIT] = 1'b1; // [RULE5]
        s_nxt.sr[`CXV_SR_BANK_BIT] = 1'b1; // [RULE6]
        s_nxt.evcode = abort_any ? ab_code : cp_code; // [RULE7]
        s_nxt.pc = s_r.vbase + (abort_any ? ab_ofs : `CXV_OFS_GEN); // [RULE8] [RULE11]
      end
    end else if (instr_end_i && irq_i && !blk) begin
      s_nxt.svpc = next_pc_i; // [RULE2] [RULE3]
      s_nxt.svsr = s_r.sr;
      s_nxt.sr[`CXV_SR_BLOCK_BIT] = 1'b1; // [RULE4]
      s_nxt.sr[`CXV_SR_PRIV_BIT] = 1'b1; // [RULE5]
      s_nxt.sr[`CXV_SR_BANK_BIT] = 1'b1; // [RULE6]
      s_nxt.icode = irq_code_i; // [RULE7]
      s_nxt.icode2 = irq_code_i;
      s_nxt.pc = s_r.vbase + `CXV_OFS_INT; // [RULE12]
      s_nxt.branch = 1'b1;
    end else if (exc_ret_i) begin
      s_nxt.pc = s_r.svpc; // [RULE15]
      s_nxt.sr = s_r.svsr;
      s_nxt.branch = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
      s_r.sr <= `CXV_SR_RST;
      s_r.pc <= `CXV_RESET_VEC;
      s_r.hready <= 1'b1;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign hrdata_o = s_r.hrdata;
  assign hreadyout_o = s_r.hready;
  assign hresp_o = 1'b0;
  assign target_pc_o = s_r.pc;
  assign branch_o = s_r.branch;
  assign abort_o = s_r.abort;
  assign cpu_regs_reset_o = s_r.creset;
  assign sr_o = s_r.sr;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  logic quiet;
  assign quiet = !any_reset && !abort_any && !comp_any;

  sequence s_entry;
    branch_o && sr_o[`CXV_SR_BLOCK_BIT] && sr_o[`CXV_SR_PRIV_BIT] && sr_o[`CXV_SR_BANK_BIT];
  endsequence

  property p_reset_vec;
    ce_i && any_reset |=> branch_o && abort_o && target_pc_o == `CXV_RESET_VEC;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset did not vector"); // [RULE9]

  property p_por_first;
    ce_i && por_i && man_reset_i |=> s_r.evcode == `CXV_EC_POR;
  endproperty
  a_por_first: assert property (p_por_first) else $error("manual reset beat power-on"); // [RULE21]

  property p_irq_wait;
    ce_i && quiet && irq_i && !instr_end_i && !exc_ret_i |=> !branch_o;
  endproperty
  a_irq_wait: assert property (p_irq_wait) else $error("interrupt taken mid-instruction"); // [RULE2]

  property p_irq_vec;
    ce_i && quiet && irq_i && instr_end_i && !blk
      |=> s_entry ##0 target_pc_o == $past(s_r.vbase) + `CXV_OFS_INT
          ##0 s_r.icode == $past(irq_code_i) ##0 !abort_o;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("bad interrupt entry"); // [RULE12]

  property p_irq_held;
    ce_i && quiet && irq_i && instr_end_i && blk && !exc_ret_i |=> !branch_o;
  endproperty
  a_irq_held: assert property (p_irq_held) else $error("interrupt taken while blocked"); // [RULE20]

  property p_irq_save;
    ce_i && quiet && irq_i && instr_end_i && !blk
      |=> s_r.svpc == $past(next_pc_i) && s_r.svsr == $past(s_r.sr);
  endproperty
  a_irq_save: assert property (p_irq_save) else $error("interrupt state not saved"); // [RULE2]

  property p_irq_code2;
    ce_i && quiet && irq_i && instr_end_i && !blk |=> s_r.icode2 == $past(irq_code_i);
  endproperty
  a_irq_code2: assert property (p_irq_code2) else $error("second interrupt code wrong"); // [RULE7]

  property p_irq_abort;
    ce_i && !any_reset && abort_any && irq_i && instr_end_i && !blk
      |=> abort_o && s_r.icode == $past(s_r.icode);
  endproperty
  a_irq_abort: assert property (p_irq_abort) else $error("interrupt beat an exception"); // [RULE1]

  property p_save;
    ce_i && !any_reset && abort_any && !blk
      |=> s_r.svpc == $past(pc_i) && s_r.svsr == $past(s_r.sr) && abort_o;
  endproperty
  a_save: assert property (p_save) else $error("state not saved on entry"); // [RULE3]

  property p_entry_bits;
    ce_i && !any_reset && abort_any && !blk |=> s_entry;
  endproperty
  a_entry_bits: assert property (p_entry_bits) else $error("status bits not set"); // [RULE4]

  property p_comp_wait;
    ce_i && !any_reset && !abort_any && comp_any && !instr_end_i && !exc_ret_i |=> !branch_o;
  endproperty
  a_comp_wait: assert property (p_comp_wait) else $error("trap taken before completion"); // [RULE19]

  property p_comp_vec;
    ce_i && !any_reset && !abort_any && comp_any && instr_end_i && !blk
      |=> s_entry ##0 !abort_o ##0 target_pc_o == $past(s_r.vbase) + `CXV_OFS_GEN
          ##0 s_r.svpc == $past(next_pc_i);
  endproperty
  a_comp_vec: assert property (p_comp_vec) else $error("completion entry wrong"); // [RULE11]

  property p_trap_code;
    ce_i && !any_reset && !abort_any && exc_i.trap && instr_end_i && !blk
      |=> s_r.evcode == `CXV_EC_TRAP;
  endproperty
  a_trap_code: assert property (p_trap_code) else $error("trap code wrong"); // [RULE17]

  property p_bkpt_code;
    ce_i && !any_reset && !abort_any && !exc_i.trap && exc_i.bkpt && instr_end_i && !blk
      |=> s_r.evcode == `CXV_EC_BKPT;
  endproperty
  a_bkpt_code: assert property (p_bkpt_code) else $error("breakpoint order wrong"); // [RULE18]

  property p_itlb;
    ce_i && !any_reset && !blk && exc_i.i_miss && !exc_i.i_adr
      |=> target_pc_o == $past(s_r.vbase) + `CXV_OFS_TLB;
  endproperty
  a_itlb: assert property (p_itlb) else $error("TLB miss offset wrong"); // [RULE10]

  property p_dtlb;
    ce_i && !any_reset && !blk && exc_i[15:9] == 7'h00 && exc_i.d_miss && !exc_i.d_in_repeat
      |=> target_pc_o == $past(s_r.vbase) + `CXV_OFS_TLB;
  endproperty
  a_dtlb: assert property (p_dtlb) else $error("data TLB miss offset wrong"); // [RULE10]

  property p_ipw;
    ce_i && !any_reset && !blk && exc_i[15:6] == 10'h000 && exc_i.ipw
      |=> abort_o && s_r.evcode == `CXV_EC_IPW
          && target_pc_o == $past(s_r.vbase) + `CXV_OFS_GEN;
  endproperty
  a_ipw: assert property (p_ipw) else $error("page write entry wrong"); // [RULE18]

  property p_order;
    ce_i && !any_reset && !blk && exc_i.i_adr && exc_i.i_miss
      |=> target_pc_o == $past(s_r.vbase) + `CXV_OFS_GEN && s_r.evcode == `CXV_EC_ADR_LD;
  endproperty
  a_order: assert property (p_order) else $error("fetch order wrong"); // [RULE16]

  property p_reset_first;
    ce_i && any_reset && abort_any |=> cpu_regs_reset_o && target_pc_o == `CXV_RESET_VEC;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("exception beat a reset"); // [RULE16]

  property p_man_code;
    ce_i && man_reset_i && !por_i |=> s_r.evcode == `CXV_EC_MAN;
  endproperty
  a_man_code: assert property (p_man_code) else $error("manual reset code wrong"); // [RULE7]

  property p_blk_reset;
    ce_i && !any_reset && abort_any && blk
      |=> cpu_regs_reset_o && target_pc_o == `CXV_RESET_VEC;
  endproperty
  a_blk_reset: assert property (p_blk_reset) else $error("blocked exception not reset"); // [RULE20]

  property p_blk_code;
    ce_i && !any_reset && abort_any && blk && !s_r.wr_pend |=> s_r.evcode == $past(s_r.evcode);
  endproperty
  a_blk_code: assert property (p_blk_code) else $error("blocked exception changed code"); // [RULE20]

  property p_ret;
    ce_i && quiet && exc_ret_i && !(irq_i && instr_end_i && !blk)
      |=> branch_o && target_pc_o == $past(s_r.svpc) && sr_o == $past(s_r.svsr);
  endproperty
  a_ret: assert property (p_ret) else $error("return did not restore"); // [RULE15]

endmodule : cxv_top

// [core/cxv_consts.svh]
`ifndef CXV_CONSTS_SVH
`define CXV_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define CXV_IDX_VBASE 3'h0
`define CXV_IDX_SVPC 3'h1
`define CXV_IDX_SVSR 3'h2
`define CXV_IDX_SR 3'h3
`define CXV_IDX_EVCODE 3'h4
`define CXV_IDX_ICODE 3'h5
`define CXV_IDX_ICODE2 3'h6
`define CXV_IDX_PC 3'h7

// Status register field positions.
`define CXV_SR_PRIV_BIT 30
`define CXV_SR_BANK_BIT 29
`define CXV_SR_BLOCK_BIT 28
`define CXV_SR_RST 32'h700000F0

`define CXV_RESET_VEC 32'hA0000000
`define CXV_OFS_GEN 32'h00000100
`define CXV_OFS_TLB 32'h00000400
`define CXV_OFS_INT 32'h00000600

// Event codes.
`define CXV_EC_POR 12'h000
`define CXV_EC_MAN 12'h020
`define CXV_EC_DBG 12'h000
`define CXV_EC_TLB_LD 12'h040
`define CXV_EC_TLB_ST 12'h060
`define CXV_EC_IPW 12'h080
`define CXV_EC_PROT_LD 12'h0A0
`define CXV_EC_PROT_ST 12'h0C0
`define CXV_EC_ADR_LD 12'h0E0
`define CXV_EC_ADR_ST 12'h100
`define CXV_EC_TRAP 12'h160
`define CXV_EC_ILL 12'h180
`define CXV_EC_SLOT 12'h1A0
`define CXV_EC_BKPT 12'h1E0
`define CXV_EC_DMA 12'h5C0

`endif

// [core/cxv_pkg.sv]
package cxv_pkg;

  typedef struct packed {
    logic i_adr;
    logic i_miss;
    logic i_inv;
    logic i_prot;
    logic illegal;
    logic slot;
    logic d_adr;
    logic d_miss;
    logic d_inv;
    logic d_prot;
    logic ipw;
    logic trap;
    logic bkpt;
    logic dma;
    logic d_store;
    logic d_in_repeat;
  } cxv_exc_req_t;

  typedef struct packed {
    logic [31:0] vbase;
    logic [31:0] svpc;
    logic [31:0] svsr;
    logic [31:0] sr;
    logic [31:0] pc;
    logic [11:0] evcode;
    logic [11:0] icode;
    logic [11:0] icode2;
    logic branch;
    logic abort;
    logic creset;
    logic rd_pend;
    logic wr_pend;
    logic [2:0] idx;
    logic hit;
    logic [31:0] hrdata;
    logic hready;
  } cxv_state_t;

endpackage : cxv_pkg

// [tb/cxv_pipe_model.sv]
`timescale 1ns/1ns
// Fetch side: steps two bytes per finished instruction and follows every redirect.
module cxv_pipe_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic fin_i,
  input wire logic branch_i,
  input wire logic [31:0] target_i,
  output logic instr_end_o,
  output logic [31:0] pc_o,
  output logic [31:0] next_pc_o
);
  assign instr_end_o = fin_i;
  assign next_pc_o = pc_o + 32'h00000002;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pc_o <= 32'h00001000;
    end else if (branch_i) begin
      pc_o <= target_i;
    end else if (fin_i) begin
      pc_o <= next_pc_o;
    end
  end
endmodule : cxv_pipe_model

// [tb/testbench.sv]
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench;
  import cxv_pkg::*;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, por = 0, man = 0, dbg = 0;
  logic irq = 0, fin = 0, ret = 0, hrdy, hresp, iend, br, ab, crr;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, pc, npc, tgt, sr, p, np, rd, s;
  logic [11:0] icode = 12'h0;
  cxv_exc_req_t exc = '0;
  int n_errors = 0, compares = 0, cyc = 0;
  // The handler table sits in untranslated space so a miss cannot recurse.
  logic [31:0] vb = 32'h80002000;
  logic [15:0] xv [15] = '{16'hC000, 16'h6000, 16'h3000, 16'h1800, 16'h0A00, 16'h0400,
    16'h0302, 16'h0180, 16'h0101, 16'h00C2, 16'h0060, 16'h0028, 16'h0010, 16'h000C, 16'h0004};
  logic [11:0] xc [15] = '{12'h0E0, 12'h040, 12'h040, 12'h0A0, 12'h180, 12'h1A0, 12'h100,
    12'h040, 12'h040, 12'h060, 12'h0A0, 12'h080, 12'h160, 12'h1E0, 12'h5C0};

  always #25 clk = ~clk;

  cxv_top u_dut (.clk_sys_i(clk), .reset_i(rst), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .por_i(por), .man_reset_i(man),
    .debug_port_reset_i(dbg), .exc_i(exc), .irq_i(irq), .irq_code_i(icode), .instr_end_i(iend),
    .pc_i(pc), .next_pc_i(npc), .exc_ret_i(ret), .target_pc_o(tgt), .branch_o(br), .abort_o(ab),
    .cpu_regs_reset_o(crr), .sr_o(sr));
  cxv_pipe_model u_pipe (.clk_sys_i(clk), .reset_i(rst), .fin_i(fin), .branch_i(br),
    .target_i(tgt), .instr_end_o(iend), .pc_o(pc), .next_pc_o(npc));

  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rd)
    `CHK("response", 1'b0, hresp)
  endtask : rchk

  task automatic unblock;
    bus(1'b1, 32'h0C, 32'h000000F0);
  endtask : unblock

  // Every request drops at the edge that takes it, so none is taken twice.
  task automatic fire;
    #1;
    p = pc;
    np = npc;
    @(posedge clk);
    exc <= '0;
    irq <= 1'b0;
    fin <= 1'b0;
    ret <= 1'b0;
    por <= 1'b0;
    man <= 1'b0;
    dbg <= 1'b0;
    #1;
  endtask : fire

  task automatic entry(input logic [31:0] et, input logic [11:0] ec, input logic ea,
    input logic [31:0] ca);
    `CHK("branch", 1'b1, br)
    `CHK("abort", ea, ab)
    `CHK("target", et, tgt)
    `CHK("mode bits", 3'h7, {sr[30], sr[29], sr[28]})
    rchk(32'h04, ea ? p : np, "saved pc");
    rchk(32'h08, 32'h000000F0, "saved sr");
    rchk(ca, {20'h0, ec}, "event code");
  endtask : entry

  task automatic t_regs;
    `CHK("reset target", 32'hA0000000, tgt)
    bus(1'b1, 32'h00, vb);
    rchk(32'h00, vb, "vector base");
    rchk(32'h40, 32'h0, "unmapped");
  endtask : t_regs

  task automatic t_general;
    for (int i = 0; i < 15; i++) begin
      unblock();
      @(posedge clk);
      exc <= cxv_exc_req_t'(xv[i]);
      fin <= (i >= 11);
      irq <= (i == 11);
      fire();
      s = vb + ((i == 1 || i == 7) ? 32'h400 : 32'h100);
      entry(s, xc[i], i < 12, 32'h10);
    end
  endtask : t_general

  task automatic t_complete;
    unblock();
    @(posedge clk);
    exc.trap <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("trap early", 1'b0, br)
    @(posedge clk);
    fin <= 1'b1;
    fire();
    `CHK("trap taken", 1'b1, br)
  endtask : t_complete

  task automatic t_irq;
    @(posedge clk);
    irq <= 1'b1;
    icode <= 12'h2A0;
    fin <= 1'b1;
    fire();
    `CHK("irq blocked", 1'b0, br)
    unblock();
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("irq early", 1'b0, br)
    @(posedge clk);
    fin <= 1'b1;
    fire();
    s = np;
    entry(vb + 32'h600, 12'h2A0, 1'b0, 32'h14);
    rchk(32'h18, 32'h2A0, "code two");
    @(posedge clk);
    ret <= 1'b1;
    fire();
    `CHK("return pc", s, tgt)
    `CHK("return sr", 32'h000000F0, sr)
  endtask : t_irq

  task automatic t_blocked;
    bus(1'b1, 32'h0C, 32'h100000F0);
    @(posedge clk);
    exc.illegal <= 1'b1;
    fire();
    `CHK("blocked target", 32'hA0000000, tgt)
    `CHK("regs reset", 1'b1, crr)
  endtask : t_blocked

  task automatic t_resets;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      por <= (k == 0);
      man <= (k < 2);
      dbg <= (k == 2);
      exc.illegal <= (k == 2);
      fire();
      `CHK("reset target", 32'hA0000000, tgt)
      rchk(32'h10, (k == 1) ? 32'h020 : 32'h000, "reset code");
    end
  endtask : t_resets

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_general();
    t_complete();
    t_irq();
    t_blocked();
    t_resets();
    finish_test();
  end
endmodule : testbench
